// *** design/pit_pkg.sv ***
/*
 * Shared constants and types of the parallel I/O and interval timer block.
 * Assumes one 40 MHz clock and a bit-addressed register port of 32 single-bit locations.
 */
package pit_pkg;

    localparam int unsigned PIT_NLINES  = 16;
    localparam int unsigned PIT_ADDR_W  = 5;
    localparam int unsigned PIT_CNT_W   = 14;
    localparam int unsigned PIT_DEC_DIV = 64;  // System clocks per counter step.

    // Bit addresses on the serial bit I/O bus.
    localparam logic [4:0] PIT_A_CTRL     = 5'h00;
    localparam logic [4:0] PIT_A_CNT_LSB  = 5'h01;
    localparam logic [4:0] PIT_A_CNT_MSB  = 5'h0e;
    localparam logic [4:0] PIT_A_SOFT_RST = 5'h0f;
    localparam logic [3:0] PIT_TIMER_LVL  = 4'h3;

    // Values after initialization.
    localparam logic [15:0] PIT_RST_PIO_OUT = 16'hffff;
    localparam logic [15:0] PIT_RST_PIO_DIR = 16'h0000;
    localparam logic [15:0] PIT_RST_MASK    = 16'h0000;
    localparam logic [13:0] PIT_RST_CNT     = 14'h0000;

    typedef enum logic {
        PIT_MODE_IRQ,
        PIT_MODE_CLK
    } pit_mode_e;

    typedef struct packed {
        logic       req_n;  // Active-low request to the processor.
        logic [3:0] code;   // Number of the winning request level.
    } pit_irq_s;

endpackage

// *** design/pit_core.sv ***
/*
 * Sixteen-line parallel port, fifteen-input interrupt prioritiser and 14-bit
 * auto-reloading interval timer behind a single-bit register port.
 * Assumes the host issues one-cycle strobes on i_ref_clk; pins are asynchronous.
 */
// The register addresses and the strobed register port were chosen for this implementation.
// Summary of operation
// RULE1: Sixteen parallel lines, each read or written alone as one bit.
// RULE2: Lines 0-6 plain I/O; lines 7-15 double as interrupts 15 down to 7.
// RULE3: A written line holds its level until written again.
// RULE4: Reinitialize on reset pin, reset instruction, or bit 15 written 0 in clock mode.
// RULE5: After initialization every line is an input, pulled high.
// RULE6: Writing a line makes it an output until the next initialization.
// RULE7: Bit 0 written 1 selects clock mode, written 0 interrupt mode.
// RULE8: In clock mode bits 1-14 hold the 14-bit start count.
// RULE9: Counter decrements right after loading, once every 64 clocks.
// RULE10: In interrupt mode bits 1 onward write the interrupt mask.
// RULE11: Host puts a 1 in the first bit of a multi-bit timer load.
// RULE12: Counter reaching zero raises a level-3 request.
// RULE13: Timer request passes only in interrupt mode with mask bit 3 set.
// RULE14: Service software clears mask bit 3 after taking the timer interrupt.
// RULE15: At zero the counter reloads the start value and keeps counting.
// RULE16: While the timer runs the external level-3 input is ignored.
// RULE17: Host holds interrupt mode a step long before reading the count.
// RULE18: Loading zero into the counter in clock mode stops the timer.
// RULE19: Only inputs whose mask bit is 1 reach the processor.
// RULE20: Lowest-numbered unmasked request is encoded; active-low request asserted.
// RULE21: Entering clock mode captures the running count for stable reads.
`timescale 1ns/1ps
module pit_core
    import pit_pkg::*;
#(
    parameter int unsigned DEC_DIV = PIT_DEC_DIV
) (
    input  wire logic                  i_ref_clk,              // System clock, 40 MHz.
    input  wire logic                  i_nrst,                 // Asynchronous reset, active low.
    input  wire logic [PIT_ADDR_W-1:0] i_addr,                 // Bit address.
    input  wire logic                  i_wr_data,              // Bit to write.
    input  wire logic                  i_wr_en,                // Write strobe.
    input  wire logic                  i_rd_en,                // Read strobe.
    output logic                       o_rd_data,              // Read bit, cycle after strobe.
    input  wire logic                  i_reset_io_instruction, // Reset instruction pulse.
    input  wire logic [PIT_NLINES-1:0] i_pio_in,               // Parallel line pin levels.
    output logic      [PIT_NLINES-1:0] o_pio_out,              // Parallel line drive levels.
    output logic      [PIT_NLINES-1:0] o_pio_oe_n,             // Low while the line is driven.
    input  wire logic [6:1]            i_irq_n,                // Dedicated interrupt pins 1-6.
    output pit_irq_s                   o_irq                   // Priority code and request.
);

    localparam int unsigned DIV_W = $clog2(DEC_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DEC_DIV - 1);

    function automatic logic [15:0] pit_put(input logic [15:0] v, input logic [3:0] idx, input logic b);
        logic [15:0] r;
        r = v;
        r[idx] = b;
        return r;
    endfunction

    function automatic logic [4:0] pit_prio(input logic [15:0] r);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 15; i >= 1; i--) begin
            if (r[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    // Two-stage synchronisers for all pin inputs.
    logic [21:0]          sync1_ff;
    logic [21:0]          sync2_ff;
    logic [15:0]          pio_lvl;
    logic [6:1]           ded_n;

    pit_mode_e            mode_ff;
    logic [15:0]          pio_out_ff;
    logic [15:0]          pio_dir_ff;
    logic [15:0]          mask_ff;
    logic [13:0]          start_ff;
    logic [13:0]          count_ff;
    logic [13:0]          snap_ff;
    logic [DIV_W-1:0]     div_ff;
    logic                 tflag_ff;
    logic                 rd_ff;
    pit_irq_s             irq_ff;

    wire                  clk_mode  = (mode_ff == PIT_MODE_CLK);
    wire [3:0]            bidx      = i_addr[3:0];
    wire                  addr_lo   = (i_addr >= PIT_A_CNT_LSB) && (i_addr <= PIT_A_CNT_MSB);
    wire                  wr_ctrl   = i_wr_en && (i_addr == PIT_A_CTRL);
    wire                  wr_15     = i_wr_en && (i_addr == PIT_A_SOFT_RST);
    wire                  wr_pio    = i_wr_en && i_addr[4];
    wire                  wr_cnt    = i_wr_en && addr_lo && clk_mode;                   // RULE8
    wire                  wr_mask   = (i_wr_en && addr_lo || wr_15) && !clk_mode;       // RULE10
    wire                  soft_rst  = wr_15 && clk_mode && !i_wr_data;                   // RULE4
    wire                  init      = soft_rst || i_reset_io_instruction;               // RULE4
    wire                  enter_clk = wr_ctrl && i_wr_data && !clk_mode;                // RULE21
    wire [15:0]           start_w   = pit_put({1'b0, start_ff, 1'b0}, bidx, i_wr_data);
    wire [13:0]           nxt_start = start_w[14:1];
    wire                  busy      = (start_ff != PIT_RST_CNT);
    wire                  step      = busy && (div_ff == DIV_LAST);
    wire                  fire      = step && (count_ff <= 14'h0001);
    wire                  tclr      = wr_cnt || (wr_mask && bidx == PIT_TIMER_LVL);
    wire                  nxt_tflag = fire || (tflag_ff && !tclr);

    assign pio_lvl = sync2_ff[15:0];
    assign ded_n   = sync2_ff[21:16];

    // Raw requests by level; bit 0 is unused so that the index is the level.
    logic [15:0] req;
    assign req[0] = 1'b0;
    genvar k;
    generate
        for (k = 1; k <= 6; k++) begin : g_ded
            if (k == 3) begin : g_lvl3
                // The timer owns level 3 while it runs; the pin is then ignored.
                assign req[k] = busy ? (tflag_ff && !clk_mode) : !ded_n[k];  // RULE16 RULE13
            end else begin : g_plain
                assign req[k] = !ded_n[k];
            end
        end
        for (k = 7; k <= 15; k++) begin : g_shared
            assign req[k] = !pio_lvl[22-k];  // RULE2
        end
    endgenerate

    wire [15:0] masked = req & mask_ff;  // RULE19
    wire [4:0]  win    = pit_prio(masked);  // RULE20

    wire rd_sel = (i_addr == PIT_A_CTRL) ? clk_mode :
                  i_addr[4]              ? pio_lvl[bidx] :                                  // RULE1
                  (clk_mode && addr_lo)  ? snap_ff[4'(bidx - 4'h1)] :                       // RULE21
                  clk_mode               ? !irq_ff.req_n : req[bidx];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_ff <= 22'h3fffff;
            sync2_ff <= 22'h3fffff;
        end else begin
            sync1_ff <= {i_irq_n, i_pio_in};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_ff    <= PIT_MODE_IRQ;
            pio_out_ff <= PIT_RST_PIO_OUT;
            pio_dir_ff <= PIT_RST_PIO_DIR;
            mask_ff    <= PIT_RST_MASK;
        end else if (init) begin
            mode_ff    <= PIT_MODE_IRQ;       // RULE4
            pio_out_ff <= PIT_RST_PIO_OUT;    // RULE5
            pio_dir_ff <= PIT_RST_PIO_DIR;    // RULE5
            mask_ff    <= PIT_RST_MASK;
        end else begin
            if (wr_ctrl) begin
                mode_ff <= i_wr_data ? PIT_MODE_CLK : PIT_MODE_IRQ;  // RULE7
            end
            if (wr_pio) begin
                pio_out_ff <= pit_put(pio_out_ff, bidx, i_wr_data);  // RULE3
                pio_dir_ff <= pit_put(pio_dir_ff, bidx, 1'b1);       // RULE6
            end
            if (wr_mask) begin
                mask_ff <= pit_put(mask_ff, bidx, i_wr_data);        // RULE10
            end
        end
    end

    // Timer. Any write to a count bit restarts the prescaler so that the first
    // step after a load is a full 64 clocks away.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_ff <= PIT_RST_CNT;
            count_ff <= PIT_RST_CNT;
            div_ff   <= '0;
            tflag_ff <= 1'b0;
        end else if (init) begin
            start_ff <= PIT_RST_CNT;
            count_ff <= PIT_RST_CNT;
            div_ff   <= '0;
            tflag_ff <= 1'b0;
        end else begin
            tflag_ff <= nxt_tflag;                                   // RULE12
            if (wr_cnt) begin
                start_ff <= nxt_start;                               // RULE18
                count_ff <= nxt_start;
                div_ff   <= '0;
            end else if (busy) begin
                div_ff <= step ? '0 : div_ff + 1'b1;                 // RULE9
                if (step) begin
                    count_ff <= fire ? start_ff : count_ff - 14'h0001;  // RULE15
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            snap_ff <= PIT_RST_CNT;
            rd_ff   <= 1'b0;
            irq_ff  <= '{req_n: 1'b1, code: 4'h0};
        end else begin
            if (enter_clk) begin
                snap_ff <= count_ff;  // RULE21
            end
            rd_ff  <= i_rd_en && rd_sel;
            irq_ff <= '{req_n: !win[4], code: win[3:0]};  // RULE20
        end
    end

    assign o_rd_data  = rd_ff;
    assign o_pio_out  = pio_out_ff;
    assign o_pio_oe_n = ~pio_dir_ff;
    assign o_irq      = irq_ff;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // Parallel lines. A write drives one line and leaves the other fifteen alone.
    a_pio_hold_level: assert property (!(wr_pio || init) |=> $stable(o_pio_out))  // RULE3
        else $error("parallel line level changed without a write");

    a_pio_write_bit: assert property (wr_pio && !init |=>                          // RULE1
        !o_pio_oe_n[$past(bidx)] && o_pio_out[$past(bidx)] == $past(i_wr_data))
        else $error("parallel write did not drive the addressed line");

    a_pio_other_bits: assert property (wr_pio && !init |=>                         // RULE1
        ((o_pio_out ^ $past(o_pio_out)) & ~(16'h0001 << $past(bidx))) == 16'h0000)
        else $error("parallel write disturbed another line");

    a_dir_sticky: assert property (!init |=> (pio_dir_ff & $past(pio_dir_ff)) == $past(pio_dir_ff))  // RULE6
        else $error("output line returned to input without initialization");

    // Initialization from the instruction pulse or the soft reset bit.
    a_init_all_inputs: assert property (init |=> o_pio_oe_n == 16'hffff && !clk_mode && !busy)  // RULE4
        else $error("initialization left a line driven or timer running");

    a_init_state: assert property (init |=> o_pio_out == PIT_RST_PIO_OUT && mask_ff == PIT_RST_MASK &&  // RULE5
        count_ff == PIT_RST_CNT && div_ff == '0 && !tflag_ff)
        else $error("initialization left a line low, a mask bit set or the timer busy");

    a_soft_ignore: assert property (wr_15 && clk_mode && i_wr_data && !i_reset_io_instruction |=>  // RULE4
        clk_mode)
        else $error("writing one to the soft reset bit reinitialized the block");

    // Mode bit and the split of bits 1 to 15 between counter and mask.
    a_mode_select: assert property (wr_ctrl && !init |=> clk_mode == $past(i_wr_data))  // RULE7
        else $error("control bit did not select the mode");

    a_mask_write: assert property (wr_mask && !init |=> mask_ff[$past(bidx)] == $past(i_wr_data))  // RULE10
        else $error("mask bit not updated in interrupt mode");

    a_mask_keeps_timer: assert property (wr_mask && !init |=> start_ff == $past(start_ff))  // RULE10
        else $error("mask write changed the start count");

    a_cnt_keeps_mask: assert property (wr_cnt && !init |=> $stable(mask_ff))  // RULE8
        else $error("count write changed the interrupt mask");

    a_cnt_load: assert property (wr_cnt && !init |=>  // RULE8
        start_ff == $past(nxt_start) && count_ff == $past(nxt_start) && div_ff == '0)
        else $error("count write did not load start, count and prescaler");

    // Prescaler and counter. The counter never shows zero while it runs; the step from one reloads it.
    a_presc_count: assert property (busy && !wr_cnt && !init && div_ff != DIV_LAST |=>  // RULE9
        div_ff == $past(div_ff) + 1'b1)
        else $error("prescaler did not advance by one");

    a_dec_rate: assert property (step && count_ff > 14'h0001 && !wr_cnt && !init |=>  // RULE9
        (count_ff == $past(count_ff) - 14'h0001) ##1 ($stable(count_ff) || $past(wr_cnt) || $past(init)))
        else $error("counter step wrong");

    a_reload_raise: assert property (fire && !wr_cnt && !init |=> count_ff == start_ff && tflag_ff)  // RULE15
        else $error("zero crossing did not reload and raise level 3");

    a_count_range: assert property (count_ff <= start_ff)  // RULE15
        else $error("running count above the start value");

    a_count_nonzero: assert property (busy |-> count_ff != 14'h0000)  // RULE15
        else $error("running counter shows zero");

    a_stop_zero: assert property (wr_cnt && nxt_start == 14'h0000 && !init |=> !busy && !step)  // RULE18
        else $error("zero load did not stop the timer");

    a_stopped_still: assert property (!busy && !wr_cnt && !init |=> $stable(count_ff))  // RULE18
        else $error("stopped counter moved");

    // Timer flag. A zero crossing in the same cycle as a clear keeps the flag set.
    a_flag_set_wins: assert property (fire && !init |=> tflag_ff)  // RULE12
        else $error("zero crossing did not set the timer flag");

    a_flag_clear: assert property (tflag_ff && tclr && !fire && !init |=> !tflag_ff)  // RULE12
        else $error("timer flag not cleared by mask or count write");

    a_level3_owner: assert property (busy |-> req[3] == (tflag_ff && !clk_mode))  // RULE16
        else $error("external level 3 seen while timer runs");

    a_clk_blocks_timer: assert property (clk_mode && busy |-> !masked[3])  // RULE13
        else $error("timer request passed in clock mode");

    // Prioritiser. The output lags the synchronised requests by one cycle.
    a_irq_encode: assert property (1'b1 |=>                                         // RULE19
        o_irq.req_n == ($past(masked) == 16'h0000) &&
        (o_irq.req_n || ((($past(masked) >> o_irq.code) & 16'h0001) == 16'h0001)))
        else $error("request output disagrees with unmasked inputs");

    a_irq_lowest: assert property (1'b1 |=>                                         // RULE20
        o_irq.req_n || (($past(masked) & ((16'h0001 << o_irq.code) - 16'h0001)) == 16'h0000))
        else $error("a lower-numbered unmasked request was passed over");

    a_masked_quiet: assert property (mask_ff == PIT_RST_MASK |=> o_irq.req_n)  // RULE19
        else $error("request raised with every mask bit clear");

    a_code_range: assert property (!o_irq.req_n |-> o_irq.code != 4'h0)  // RULE20
        else $error("active request carries code zero");

    a_idle_code: assert property (o_irq.req_n |-> o_irq.code == 4'h0)  // RULE20
        else $error("idle request output carries a code");

    a_shared_lines: assert property (!pio_lvl[15] && mask_ff[7] |=> !o_irq.req_n)  // RULE2
        else $error("low last line did not raise request level 7");

    a_ded_lines: assert property (!ded_n[1] && mask_ff[1] |=> !o_irq.req_n && o_irq.code == 4'h1)  // RULE20
        else $error("level 1 did not win the priority");

    a_timer_request: assert property (busy && tflag_ff && !clk_mode && mask_ff[3] |=> !o_irq.req_n)  // RULE13
        else $error("unmasked timer request did not reach the processor");

    // Read port and count snapshot.
    a_read_idle: assert property (!i_rd_en |=> !o_rd_data)  // RULE1
        else $error("read data high without a read strobe");

    a_read_mode: assert property (i_rd_en && i_addr == PIT_A_CTRL |=> o_rd_data == $past(clk_mode))  // RULE7
        else $error("control bit read back wrong");

    a_read_line: assert property (i_rd_en && i_addr[4] |=> o_rd_data == $past(pio_lvl[bidx]))  // RULE1
        else $error("line read did not return the pin level");

    a_snapshot: assert property (enter_clk && !init |=> snap_ff == $past(count_ff))  // RULE21
        else $error("count snapshot not captured on entering clock mode");

    a_snap_hold: assert property (!enter_clk |=> $stable(snap_ff))  // RULE21
        else $error("count snapshot changed without a mode change");

endmodule

// *** dv/pit_host_model.sv ***
/* Host side of the single-bit register port: bus cycles and the timer sequences that software uses.
   Assumes one clock shared with the block, which answers every read in the cycle after the strobe. */
`timescale 1ns/1ps
module pit_host_model
    import pit_pkg::*;
#(
    parameter int unsigned STEP = PIT_DEC_DIV
) (
    input  wire logic                  i_ref_clk, // System clock.
    input  wire logic                  i_rd_data, // Read bit.
    output logic      [PIT_ADDR_W-1:0] o_addr,    // Bit address.
    output logic                       o_wr_data, // Write bit.
    output logic                       o_wr_en,   // Write strobe.
    output logic                       o_rd_en    // Read strobe.
);
    initial begin
        o_addr    = '0;
        o_wr_data = 1'b0;
        o_wr_en   = 1'b0;
        o_rd_en   = 1'b0;
    end
    // Released lines are inverted so the block cannot lean on a stale value.
    task automatic wr(input logic [4:0] a, input logic d);
        @(posedge i_ref_clk);
        o_addr    <= a;
        o_wr_data <= d;
        o_wr_en   <= 1'b1;
        @(posedge i_ref_clk);
        o_wr_en   <= 1'b0;
        o_addr    <= ~a;
        o_wr_data <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic d);
        @(posedge i_ref_clk);
        o_addr  <= a;
        o_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        @(posedge i_ref_clk);
        d = i_rd_data;
    endtask
    // The mode bit goes first, as in one multi-bit load.
    task automatic load_timer(input logic [13:0] start);
        wr(PIT_A_CTRL, 1'b1);
        for (int b = 0; b < 14; b++) wr(5'(b + 1), start[b]);
    endtask
    task automatic read_count(output logic [13:0] c);
        logic d;
        wr(PIT_A_CTRL, 1'b0);
        repeat (STEP + 2) @(posedge i_ref_clk);
        wr(PIT_A_CTRL, 1'b1);
        for (int b = 0; b < 14; b++) begin
            rd(5'(b + 1), d);
            c[b] = d;
        end
    endtask
endmodule

// *** dv/tb.sv ***
/* Self-checking bench of the parallel I/O and interval timer block.
   Assumes pit_core and pit_host_model; expected values come from the bench alone. */
`timescale 1ns/1ps
module tb
    import pit_pkg::*;
;
    localparam int unsigned DIV = 4;
    logic        clk, nrst, rst_ins, rd_data, wd, we, re, v;
    logic [4:0]  addr;
    logic [3:0]  n;
    logic [15:0] ext_ff, pin, pout, poe_n, exp_out, exp_drv;
    logic [6:1]  irq_n;
    logic [15:1] req;
    logic [13:0] cnt;
    logic [31:0] rng;
    pit_irq_s    irq;
    int          err_count, total_checks, cyc, t1;
    assign pin = (~poe_n & pout) | (poe_n & ext_ff);
    pit_core #(.DEC_DIV(DIV)) i_pit_core (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr_data(wd),
        .i_wr_en(we), .i_rd_en(re), .o_rd_data(rd_data), .i_reset_io_instruction(rst_ins), .i_pio_in(pin),
        .o_pio_out(pout), .o_pio_oe_n(poe_n), .i_irq_n(irq_n), .o_irq(irq));
    pit_host_model #(.STEP(DIV)) i_pit_host_model (.i_ref_clk(clk), .i_rd_data(rd_data), .o_addr(addr),
        .o_wr_data(wd), .o_wr_en(we), .o_rd_en(re));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] prio(input logic [15:1] r);
        for (int k = 1; k < 16; k++) if (r[k]) return 16'(k);
        return 16'h0010;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_req(input logic w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if (irq.req_n === w) break;
        end
        if (i == lim) begin
            chk("request wait", 16'(w), 16'(irq.req_n));
            results();
        end
    endtask
    task automatic hold_req(input logic w, input int lim);
        logic bad;
        bad = 1'b0;
        repeat (lim) begin
            @(negedge clk);
            bad = bad | (irq.req_n !== w);
        end
        chk("request held", 16'h0, 16'(bad));
    endtask
    initial begin
        nrst = 1'b0;
        rst_ins = 1'b0;
        irq_n = '1;
        ext_ff = '1;
        exp_drv = '0;
        rng = 32'ha070;
        cyc = 0;
        err_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("enables at reset", 16'hffff, poe_n);
        chk("levels at reset", 16'hffff, pout);
        repeat (40) begin
            rng = xs(rng);
            n = rng[3:0];
            i_pit_host_model.wr(5'(16 + n), rng[4]);
            exp_out[n] = rng[4];
            exp_drv[n] = 1'b1;
            ext_ff <= rng[31:16];
            @(negedge clk);
            chk("driven levels", exp_out & exp_drv, pout & exp_drv);
            chk("line enables", ~exp_drv, poe_n);
            n = rng[8:5];
            repeat (3) @(posedge clk);
            i_pit_host_model.rd(5'(16 + n), v);
            chk("line read", 16'(exp_drv[n] ? exp_out[n] : rng[16 + n]), 16'(v));
        end
        i_pit_host_model.wr(PIT_A_CTRL, 1'b1);
        i_pit_host_model.rd(PIT_A_CTRL, v);
        chk("clock mode", 16'h1, 16'(v));
        i_pit_host_model.wr(PIT_A_SOFT_RST, 1'b0);
        @(negedge clk);
        chk("soft init", 16'hffff, poe_n);
        i_pit_host_model.rd(PIT_A_CTRL, v);
        chk("mode after init", 16'h0, 16'(v));
        i_pit_host_model.wr(5'h10, 1'b0);
        rst_ins <= 1'b1;
        @(posedge clk);
        rst_ins <= 1'b0;
        @(negedge clk);
        chk("instruction init", 16'hffff, poe_n);
        $display("test lines and init done");
        repeat (8) begin
            rng = xs(rng);
            for (int k = 1; k < 16; k++) i_pit_host_model.wr(5'(k), rng[k]);
            irq_n <= rng[22:17];
            ext_ff <= {rng[31:23], 7'h7f};
            repeat (5) @(negedge clk);
            req[6:1] = ~irq_n & rng[6:1];
            for (int k = 7; k < 16; k++) req[k] = ~ext_ff[22 - k] & rng[k];
            chk("priority", prio(req), irq.req_n === 1'b1 ? 16'h0010 : 16'({irq.req_n, irq.code}));
        end
        $display("test interrupts done");
        @(posedge clk);
        rst_ins <= 1'b1;
        irq_n <= 6'h3b;
        ext_ff <= '1;
        @(posedge clk);
        rst_ins <= 1'b0;
        i_pit_host_model.load_timer(14'h0003);
        i_pit_host_model.wr(PIT_A_CTRL, 1'b0);
        i_pit_host_model.wr(5'h03, 1'b1);
        hold_req(1'b1, 2);
        wait_req(1'b0, 20);
        t1 = cyc;
        chk("timer level", 16'(PIT_TIMER_LVL), 16'(irq.code));
        i_pit_host_model.wr(5'h03, 1'b0);
        wait_req(1'b1, 4);
        i_pit_host_model.wr(5'h03, 1'b1);
        wait_req(1'b0, 20);
        chk("reload period", 16'(3 * DIV), 16'(cyc - t1));
        i_pit_host_model.read_count(cnt);
        chk("count snapshot", 16'h1, 16'(cnt inside {[14'h1:14'h3]}));
        hold_req(1'b1, 30);
        @(posedge clk);
        irq_n <= '1;
        i_pit_host_model.load_timer(14'h0000);
        i_pit_host_model.wr(PIT_A_CTRL, 1'b0);
        i_pit_host_model.wr(5'h03, 1'b1);
        hold_req(1'b1, 30);
        @(posedge clk);
        irq_n <= 6'h3b;
        wait_req(1'b0, 8);
        chk("idle pin level", 16'(PIT_TIMER_LVL), 16'(irq.code));
        $display("test timer done");
        results();
    end
endmodule
